// file: core/cwt_pkg.sv
// package of timing constants for the card cycle wait timer
`default_nettype none
package cwt_pkg;
	localparam int CWT_CNT_W = 5;
	localparam int CWT_CLK_NS = 100;
	// ------------------------------------------------------------
	// clock counts for timing select 01
	// ------------------------------------------------------------
	localparam logic [1:0] CWT_TS_REF = 2'h1;
	localparam logic [4:0] CWT_SU_IO = 5'h3;
	localparam logic [4:0] CWT_SU_MEM_LO = 5'h2;
	localparam logic [4:0] CWT_SU_MEM_HI = 5'h4;
	localparam logic [4:0] CWT_ACT8_NOWAIT = 5'h13;
	localparam logic [4:0] CWT_ACT8_WAIT = 5'h17;
	localparam logic [4:0] CWT_ACT8_ZERO = 5'h7;
	localparam logic [4:0] CWT_ACT16_IO = 5'h7;
	localparam logic [4:0] CWT_ACT16_IO_WAIT = 5'hb;
	localparam logic [4:0] CWT_ACT16_MEM0 = 5'h9;
	localparam logic [4:0] CWT_ACT16_MEM1 = 5'hd;
	localparam logic [4:0] CWT_ACT16_MEM2 = 5'h11;
	localparam logic [4:0] CWT_ACT16_MEM3 = 5'h17;
	localparam logic [4:0] CWT_ACT16_ZERO = 5'h5;
	localparam logic [4:0] CWT_HOLD_IO = 5'h2;
	localparam logic [4:0] CWT_HOLD_MEM_LO = 5'h2;
	localparam logic [4:0] CWT_HOLD_MEM_HI = 5'h3;
	localparam logic [4:0] CWT_MEM_SU_EXTRA = 5'h2;
	localparam logic [4:0] CWT_MEM_HOLD_EXTRA = 5'h1;
	// default counts for other timing selects
	localparam logic [4:0] CWT_ALT_SU = 5'h4;
	localparam logic [4:0] CWT_ALT_ACT = 5'h17;
	localparam logic [4:0] CWT_ALT_HOLD = 5'h3;
	typedef enum logic [1:0] {CWT_IDLE, CWT_SETUP, CWT_ACTIVE, CWT_HOLD} cwt_state_e;
endpackage : cwt_pkg
`default_nettype wire

// file: core/cwt_timer.sv
// card cycle wait timer: address setup, strobe width and address hold
`default_nettype none
module cwt_timer #(
	parameter logic [4:0] P_ALT_SU = cwt_pkg::CWT_ALT_SU,
	parameter logic [4:0] P_ALT_ACT = cwt_pkg::CWT_ALT_ACT,
	parameter logic [4:0] P_ALT_HOLD = cwt_pkg::CWT_ALT_HOLD
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_start,
	input wire logic i_is_mem,
	input wire logic i_is_16bit,
	input wire logic [1:0] i_wait_state_code,
	input wire logic i_zero_wait_request,
	input wire logic [1:0] i_timing_select_field,
	input wire logic i_card_wait_n,
	output logic o_busy,
	output logic o_addr_valid,
	output logic o_strobe_n,
	output logic o_done
);
	import cwt_pkg::*;

	// ------------------------------------------------------------
	// interval selection
	// ------------------------------------------------------------
	function automatic logic [4:0] sel_setup(input logic mem, input logic [1:0] ws,
		input logic [1:0] ts);
		if (ts != CWT_TS_REF) return P_ALT_SU;
		if (!mem) return CWT_SU_IO;
		return (ws[1] ? CWT_SU_MEM_HI : CWT_SU_MEM_LO) + CWT_MEM_SU_EXTRA;
	endfunction : sel_setup

	function automatic logic [4:0] sel_act(input logic mem, input logic w16,
		input logic [1:0] ws, input logic zw, input logic [1:0] ts);
		if (ts != CWT_TS_REF) return P_ALT_ACT;
		if (!w16) begin
			if (ws != 2'h0) return CWT_ACT8_WAIT;
			return zw ? CWT_ACT8_ZERO : CWT_ACT8_NOWAIT;
		end
		if (!mem) return ws[0] ? CWT_ACT16_IO_WAIT : CWT_ACT16_IO;
		case (ws)
			2'h0: return zw ? CWT_ACT16_ZERO : CWT_ACT16_MEM0;
			2'h1: return CWT_ACT16_MEM1;
			2'h2: return CWT_ACT16_MEM2;
			default: return CWT_ACT16_MEM3;
		endcase
	endfunction : sel_act

	function automatic logic [4:0] sel_hold(input logic mem, input logic [1:0] ws,
		input logic [1:0] ts);
		if (ts != CWT_TS_REF) return P_ALT_HOLD;
		if (!mem) return CWT_HOLD_IO;
		return (ws[1] ? CWT_HOLD_MEM_HI : CWT_HOLD_MEM_LO) + CWT_MEM_HOLD_EXTRA;
	endfunction : sel_hold

	// ------------------------------------------------------------
	// cycle sequencer
	// ------------------------------------------------------------
	cwt_state_e state_q, state_d;
	logic [CWT_CNT_W-1:0] cnt_q, cnt_d;
	logic [4:0] act_q, act_d;
	logic [4:0] hold_q, hold_d;
	logic busy_d, addr_d, strobe_n_d, done_d;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		act_d = act_q;
		hold_d = hold_q;
		done_d = 1'b0;
		case (state_q)
			CWT_IDLE: begin
				if (i_start) begin
					// settings captured once per card cycle
					cnt_d = sel_setup(i_is_mem, i_wait_state_code, i_timing_select_field);
					act_d = sel_act(i_is_mem, i_is_16bit, i_wait_state_code,
						i_zero_wait_request, i_timing_select_field);
					hold_d = sel_hold(i_is_mem, i_wait_state_code, i_timing_select_field);
					state_d = CWT_SETUP;
				end
			end
			CWT_SETUP: begin
				if (cnt_q == 5'h1) begin
					cnt_d = act_q;
					state_d = CWT_ACTIVE;
				end else begin
					cnt_d = cnt_q - 5'h1;
				end
			end
			CWT_ACTIVE: begin
				if (cnt_q != 5'h1) begin
					cnt_d = cnt_q - 5'h1;
				end else if (i_card_wait_n) begin
					cnt_d = hold_q;
					state_d = CWT_HOLD;
				end
			end
			CWT_HOLD: begin
				if (cnt_q == 5'h1) begin
					state_d = CWT_IDLE;
					done_d = 1'b1;
				end else begin
					cnt_d = cnt_q - 5'h1;
				end
			end
			default: state_d = CWT_IDLE;
		endcase
		busy_d = (state_d != CWT_IDLE);
		addr_d = busy_d;
		strobe_n_d = (state_d != CWT_ACTIVE);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			state_q <= CWT_IDLE;
			cnt_q <= '0;
			act_q <= '0;
			hold_q <= '0;
			o_busy <= 1'b0;
			o_addr_valid <= 1'b0;
			o_strobe_n <= 1'b1;
			o_done <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			act_q <= act_d;
			hold_q <= hold_d;
			o_busy <= busy_d;
			o_addr_valid <= addr_d;
			o_strobe_n <= strobe_n_d;
			o_done <= done_d;
		end
	end

	// ------------------------------------------------------------
	// cycle monitor for the checks
	// ------------------------------------------------------------
	logic mon_mem_q, mon_mem_d;
	logic mon_w16_q, mon_w16_d;
	logic mon_ws1_q, mon_ws1_d;
	logic mon_ref_q, mon_ref_d;
	logic [4:0] mon_low_q, mon_low_d;

	always_comb begin
		mon_mem_d = mon_mem_q;
		mon_w16_d = mon_w16_q;
		mon_ws1_d = mon_ws1_q;
		mon_ref_d = mon_ref_q;
		if (state_q == CWT_IDLE && i_start) begin
			mon_mem_d = i_is_mem;
			mon_w16_d = i_is_16bit;
			mon_ws1_d = i_wait_state_code[1];
			mon_ref_d = (i_timing_select_field == CWT_TS_REF);
		end
		// strobe low length, saturating so a long card wait cannot wrap it
		if (o_strobe_n) begin
			mon_low_d = '0;
		end else if (mon_low_q != '1) begin
			mon_low_d = mon_low_q + 5'h1;
		end else begin
			mon_low_d = mon_low_q;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			mon_mem_q <= 1'b0;
			mon_w16_q <= 1'b0;
			mon_ws1_q <= 1'b0;
			mon_ref_q <= 1'b0;
			mon_low_q <= '0;
		end else begin
			mon_mem_q <= mon_mem_d;
			mon_w16_q <= mon_w16_d;
			mon_ws1_q <= mon_ws1_d;
			mon_ref_q <= mon_ref_d;
			mon_low_q <= mon_low_d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	chk_strobe_addr_valid: assert property (!o_strobe_n |-> o_addr_valid)
		else $error("strobe low without valid address");
	chk_io8_strobe_width: assert property (
		$rose(o_addr_valid) && state_q == CWT_SETUP && act_q == CWT_ACT8_NOWAIT
		|-> ##[1:6] $fell(o_strobe_n) ##1 (!o_strobe_n) [*8])
		else $error("8-bit strobe ended too early");
	chk_wait_holds_strobe: assert property (
		state_q == CWT_ACTIVE && cnt_q == 5'h1 && !i_card_wait_n |=> !o_strobe_n)
		else $error("strobe released while card wait low");
	chk_mem_setup_lead: assert property (
		$rose(o_addr_valid) && state_q == CWT_SETUP && cnt_q == 5'h4 |-> o_strobe_n [*4])
		else $error("memory setup too short");
	chk_hold_after_strobe: assert property (
		$rose(o_strobe_n) && o_busy |-> o_addr_valid ##1 o_addr_valid)
		else $error("address dropped before hold ended");
	chk_done_ends_cycle: assert property (o_done |-> !o_busy && !o_addr_valid)
		else $error("done while cycle still running");
	chk_latched_settings: assert property (
		state_q != CWT_IDLE && state_d != CWT_IDLE |=> $stable(act_q) && $stable(hold_q))
		else $error("settings changed inside a cycle");
	chk_strobe_nonzero: assert property ($fell(o_strobe_n) |=> !o_strobe_n)
		else $error("strobe shorter than two clocks");
	chk_io_setup_exact: assert property (
		$rose(o_addr_valid) && !mon_mem_q && mon_ref_q |-> o_strobe_n [*3] ##1 !o_strobe_n)
		else $error("io address setup not three clocks");
	chk_mem_setup_margin: assert property (
		$fell(o_strobe_n) && mon_mem_q && mon_ref_q
		|-> $past(o_addr_valid, 4) && (!mon_ws1_q || $past(o_addr_valid, 6)))
		else $error("memory address lead below setup plus two");
	chk_io_hold_exact: assert property (
		$rose(o_strobe_n) && o_busy && !mon_mem_q && mon_ref_q
		|-> o_addr_valid ##1 o_addr_valid ##1 !o_addr_valid)
		else $error("io address hold not two clocks");
	chk_mem_hold_margin: assert property (
		$rose(o_strobe_n) && o_busy && mon_mem_q && mon_ref_q
		|-> o_addr_valid [*3] ##1 (o_addr_valid || !mon_ws1_q))
		else $error("memory address hold below hold plus one");
	chk_strobe_8bit_len: assert property (
		$rose(o_strobe_n) && o_busy && mon_ref_q && !mon_w16_q
		|-> mon_low_q == CWT_ACT8_ZERO || mon_low_q >= CWT_ACT8_NOWAIT)
		else $error("8-bit strobe width off the table");
	chk_strobe_16bit_min: assert property (
		$rose(o_strobe_n) && o_busy && mon_ref_q && mon_w16_q
		|-> mon_low_q >= (mon_mem_q ? CWT_ACT16_ZERO : CWT_ACT16_IO))
		else $error("16-bit strobe shorter than the table");

	cov_mem16_cycle: cover property (i_start && i_is_mem && i_is_16bit ##[1:40] o_done);
	cov_io8_zero: cover property (i_start && !i_is_mem && i_zero_wait_request ##[1:40] o_done);
	cov_card_wait: cover property (state_q == CWT_ACTIVE && !i_card_wait_n && cnt_q == 5'h1);
	cov_back_to_back: cover property (o_done && i_start);
	cov_alt_select: cover property (state_q == CWT_IDLE && i_start
		&& i_timing_select_field != CWT_TS_REF);
endmodule : cwt_timer
`default_nettype wire

// file: dv/cwt_card_model.sv
// card model that stretches the strobe with its wait line
`default_nettype none
module cwt_card_model (
	input wire logic i_mclk,
	input wire logic i_strobe_n,
	input wire logic [4:0] i_stretch,
	output logic o_card_wait_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_q;
	always_ff @(posedge i_mclk) begin
		cnt_q <= i_strobe_n ? 5'h0 : cnt_q + 5'h1;
	end
	// wait pulled high whenever the strobe is not low
	assign o_card_wait_n = i_strobe_n | (cnt_q >= i_stretch);
endmodule : cwt_card_model
`default_nettype wire

// file: dv/card_cycle_wait_timer_test.sv
// testbench for the card cycle wait timer
`default_nettype none
module card_cycle_wait_timer_test;
	timeunit 1ns;
	timeprecision 1ns;
	import cwt_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, mem = 1'b0, b16 = 1'b0, zw = 1'b0, wt_n;
	logic [1:0] ws = 2'h0, ts = 2'h1;
	logic [4:0] k = 5'h0;
	logic busy, av, sn, done;
	int mismatches = 0, compares = 0;
	logic [4:0] act16 [4] = '{5'h09, 5'h0d, 5'h11, 5'h17};
	always #50 clk = ~clk;
	cwt_timer cwt_timer_i (.i_mclk(clk), .i_reset_n(rst_n), .i_start(start),
		.i_is_mem(mem), .i_is_16bit(b16), .i_wait_state_code(ws),
		.i_zero_wait_request(zw), .i_timing_select_field(ts), .i_card_wait_n(wt_n),
		.o_busy(busy), .o_addr_valid(av), .o_strobe_n(sn), .o_done(done));
	cwt_card_model cwt_card_model_i (.i_mclk(clk), .i_strobe_n(sn), .i_stretch(k),
		.o_card_wait_n(wt_n));
	task cmp(input logic [4:0] seen, input logic [4:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : cmp
	task summarize;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize
	task automatic cyc(input logic m, input logic b, input logic [1:0] w, input logic z,
		input logic [1:0] t, input logic [4:0] ea, input logic [4:0] sk, input logic hold);
		int n;
		logic [4:0] s, a, h, es, eh;
		es = !m ? 5'h3 : (w[1] ? 5'h6 : 5'h4);
		eh = !m ? 5'h2 : (w[1] ? 5'h4 : 5'h3);
		@(posedge clk);
		{mem, b16, ws, zw, ts, k, start} <= {m, b, w, z, t, sk, 1'b1};
		@(posedge clk);
		start <= hold;
		s = 5'h0;
		a = 5'h0;
		h = 5'h0;
		n = 0;
		#1;
		cmp({4'h0, busy}, 5'h1);
		while (sn !== 1'b0 && n < 99) begin s++; n++; @(posedge clk); #1; end
		while (sn === 1'b0 && n < 99) begin a++; n++; @(posedge clk); #1; end
		while (av === 1'b1 && n < 99) begin h++; n++; @(posedge clk); #1; end
		cmp(s, t == CWT_TS_REF ? es : CWT_ALT_SU);
		if (sk > ea) cmp({4'h0, a >= sk && a <= sk + 5'h2}, 5'h1);
		else cmp(a, t == CWT_TS_REF ? ea : CWT_ALT_ACT);
		cmp(h, t == CWT_TS_REF ? eh : CWT_ALT_HOLD);
		cmp({4'h0, done}, 5'h1);
		cmp({4'h0, busy}, 5'h0);
		cmp({4'h0, n >= 99}, 5'h0);
	endtask : cyc
	task io_cycles;
		cyc(0, 0, 0, 0, 1, 5'h13, 0, 0);
		cyc(0, 0, 1, 0, 1, 5'h17, 0, 0);
		cyc(0, 0, 0, 1, 1, 5'h07, 0, 0);
		cyc(0, 1, 0, 0, 1, 5'h07, 0, 0);
		cyc(0, 1, 1, 0, 1, 5'h0b, 0, 0);
		cyc(0, 1, 0, 1, 1, 5'h07, 0, 0);
	endtask : io_cycles
	task mem_cycles;
		for (int w = 0; w < 4; w++) begin
			cyc(1, 0, w[1:0], 0, 1, w == 0 ? 5'h13 : 5'h17, 0, 0);
			cyc(1, 1, w[1:0], 0, 1, act16[w], 0, 0);
		end
		cyc(1, 0, 0, 1, 1, 5'h07, 0, 0);
		cyc(1, 1, 0, 1, 1, 5'h05, 0, 0);
	endtask : mem_cycles
	task alt_select;
		cyc(1, 0, 2'h3, 0, 2'h0, 0, 0, 0);
		cyc(0, 1, 2'h0, 0, 2'h2, 0, 0, 0);
	endtask : alt_select
	task wait_stretch;
		cyc(1, 1, 0, 0, 1, 5'h09, 5'h0e, 0);
		cyc(0, 0, 0, 0, 1, 5'h13, 5'h04, 0);
	endtask : wait_stretch
	task back_to_back;
		int n;
		cyc(0, 1, 0, 0, 1, 5'h07, 0, 1);
		@(posedge clk);
		start <= 1'b0;
		#1;
		cmp({4'h0, av}, 5'h1);
		for (n = 0; n < 60 && busy !== 1'b0; n++) begin @(posedge clk); #1; end
		cmp({4'h0, busy}, 5'h0);
	endtask : back_to_back
	task reset_mid_cycle;
		@(posedge clk);
		{mem, b16, ws, zw, ts, k, start} <= {1'b0, 1'b0, 2'h0, 1'b0, 2'h1, 5'h0, 1'b1};
		@(posedge clk);
		start <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		cmp({1'b0, busy, av, ~sn, done}, 5'h0);
		cyc(0, 0, 0, 0, 1, 5'h13, 0, 0);
	endtask : reset_mid_cycle
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		io_cycles;
		mem_cycles;
		alt_select;
		wait_stretch;
		back_to_back;
		reset_mid_cycle;
		summarize;
	end
	initial begin
		#2000000;
		mismatches++;
		summarize;
	end
endmodule : card_cycle_wait_timer_test
`default_nettype wire
